// *** dv/accumulator_saturate_round_bench.sv ***
// Bench for the accumulator datapath: APB and operation tasks
// Assumes asr_top, asr_xmem and asr_properties compiled first
`timescale 1ns/1ps
`default_nettype none
`include "asr_defs.svh"
module accumulator_saturate_round_bench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, r;
   logic pready, pslverr, op_valid = 1'b0, op_target_b = 1'b0, op_subtract = 1'b0, op_round = 1'b0;
   asr_pkg::asr_op_type op_kind = asr_pkg::ASR_OP_NONE;
   asr_pkg::asr_wb_type op_wb_mode = asr_pkg::ASR_WB_NONE;
   logic [39:0] op_operand = 40'h00_0000_0000;
   logic xbus_wr_q, arith_trap_q, irq, e;
   logic [15:0] xbus_addr_q, xbus_data_q, m_addr, m_data;
   logic [7:0] m_cnt;
   int n_fail = 0, n_checks = 0, i;
   logic [31:0] t_lo [6] = '{32'h1234_8000, 32'h1234_8000, 32'h1234_7FFF, 32'h1234_8000, 32'h1235_8000, 32'h1235_8001};
   logic [1:0] t_cfg [6] = '{2'h0, 2'h1, 2'h1, 2'h3, 2'h3, 2'h3};
   logic [15:0] t_exp [6] = '{16'h1234, 16'h1235, 16'h1234, 16'h1234, 16'h1236, 16'h1236};
   always #2.5 pclk = ~pclk;
   asr_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .op_valid, .op_kind, .op_target_b, .op_subtract, .op_operand, .op_round, .op_wb_mode,
      .xbus_wr_q, .xbus_addr_q, .xbus_data_q, .arith_trap_q, .irq);
   asr_xmem xm_u (.pclk, .presetn, .wr(xbus_wr_q), .addr(xbus_addr_q), .data(xbus_data_q),
      .last_addr(m_addr), .last_data(m_data), .n_wr(m_cnt));
   // =====================================================================
   // Verdict, compare and access tasks
   task automatic report_and_stop;
      if (n_fail == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 16) begin
         n_fail++;
         report_and_stop();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk(r, x);
   endtask : rd
   task automatic op(input asr_pkg::asr_op_type k, input logic b, input logic s, input logic [39:0] v,
                     input logic rn, input asr_pkg::asr_wb_type m);
      @(posedge pclk);
      op_valid <= 1'b1;
      op_kind <= k;
      op_target_b <= b;
      op_subtract <= s;
      op_operand <= v;
      op_round <= rn;
      op_wb_mode <= m;
      @(posedge pclk);
      op_valid <= 1'b0;
      #1;
   endtask : op
   // =====================================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(`ASR_STATUS_ADDR, 32'h0000_0000);
      rd(12'h040, 32'h0000_0000);
      chk({31'h0, e}, 32'h0000_0001);
      // 40-bit saturation on A with interrupt unmasked
      apb(1'b1, `ASR_IRQ_MASK_ADDR, 32'h0000_0001);
      apb(1'b1, `ASR_CORE_CTRL_ADDR, 32'h0000_000A);
      op(asr_pkg::ASR_OP_ADD, 1'b0, 1'b0, 40'h7F_FFFF_FFFF, 1'b0, asr_pkg::ASR_WB_NONE);
      op(asr_pkg::ASR_OP_ADD, 1'b0, 1'b0, 40'h00_0000_0001, 1'b0, asr_pkg::ASR_WB_NONE);
      chk({31'h0, irq}, 32'h0000_0001);
      rd(`ASR_ACC_A_LO_ADDR, 32'hFFFF_FFFF);
      rd(`ASR_ACC_A_HI_ADDR, 32'h0000_007F);
      rd(`ASR_STATUS_ADDR, 32'h0000_0035);
      rd(`ASR_IRQ_STAT_ADDR, 32'h0000_0001);
      #1;
      chk({31'h0, irq}, 32'h0000_0000);
      apb(1'b1, `ASR_STATUS_ADDR, 32'h0000_0000);
      rd(`ASR_STATUS_ADDR, 32'h0000_0000);
      // 32-bit saturation on B, both signs, masked event
      apb(1'b1, `ASR_CORE_CTRL_ADDR, 32'h0000_0004);
      op(asr_pkg::ASR_OP_ADD, 1'b1, 1'b0, 40'h00_7FFF_FFFF, 1'b0, asr_pkg::ASR_WB_NONE);
      op(asr_pkg::ASR_OP_ADD, 1'b1, 1'b0, 40'h00_0000_0001, 1'b0, asr_pkg::ASR_WB_NONE);
      rd(`ASR_ACC_B_LO_ADDR, 32'h7FFF_FFFF);
      op(asr_pkg::ASR_OP_ADD, 1'b1, 1'b1, 40'h01_0000_0000, 1'b0, asr_pkg::ASR_WB_NONE);
      chk({31'h0, irq}, 32'h0000_0000);
      rd(`ASR_ACC_B_LO_ADDR, 32'h8000_0000);
      rd(`ASR_ACC_B_HI_ADDR, 32'h0000_00FF);
      rd(`ASR_STATUS_ADDR, 32'h0000_0012);
      rd(`ASR_IRQ_STAT_ADDR, 32'h0000_0002);
      // Catastrophic wrap on A with trap enabled
      apb(1'b1, `ASR_IRQ_MASK_ADDR, 32'h0000_0000);
      apb(1'b1, `ASR_CORE_CTRL_ADDR, 32'h0000_0000);
      apb(1'b1, `ASR_IRQ_CTRL1_ADDR, 32'h0000_0001);
      op(asr_pkg::ASR_OP_ADD, 1'b0, 1'b0, 40'h00_0000_0001, 1'b0, asr_pkg::ASR_WB_NONE);
      chk({31'h0, arith_trap_q}, 32'h0000_0001);
      rd(`ASR_ACC_A_HI_ADDR, 32'h0000_0080);
      apb(1'b0, `ASR_STATUS_ADDR, 32'h0000_0000);
      chk(r & 32'h0000_0011, 32'h0000_0011);
      rd(`ASR_IRQ_STAT_ADDR, 32'h0000_0005);
      rd(`ASR_IRQ_STAT_ADDR, 32'h0000_0000);
      apb(1'b1, `ASR_IRQ_CTRL1_ADDR, 32'h0000_0000);
      // Store rounding table on A
      apb(1'b1, `ASR_WB_PTR_ADDR, 32'h0000_0100);
      apb(1'b1, `ASR_ACC_A_HI_ADDR, 32'h0000_0000);
      for (i = 0; i < 6; i++) begin
         apb(1'b1, `ASR_CORE_CTRL_ADDR, {31'h0, t_cfg[i][1]});
         apb(1'b1, `ASR_ACC_A_LO_ADDR, t_lo[i]);
         op(asr_pkg::ASR_OP_STORE, 1'b0, 1'b0, 40'h00_0000_0000, t_cfg[i][0], asr_pkg::ASR_WB_NONE);
         chk({xbus_addr_q, xbus_data_q}, {16'h0100, t_exp[i]});
      end
      // Write-back of the other accumulator from MAC on B
      apb(1'b1, `ASR_ACC_A_LO_ADDR, 32'h1235_8000);
      op(asr_pkg::ASR_OP_MAC, 1'b1, 1'b0, 40'h00_0000_0000, 1'b0, asr_pkg::ASR_WB_INDIRECT_INC);
      chk({xbus_addr_q, xbus_data_q}, 32'h0100_1236);
      rd(`ASR_WB_PTR_ADDR, 32'h0000_0102);
      chk({m_addr, m_data}, 32'h0100_1236);
      apb(1'b1, `ASR_CORE_CTRL_ADDR, 32'h0000_0001);
      apb(1'b1, `ASR_ACC_A_LO_ADDR, 32'h1234_8000);
      op(asr_pkg::ASR_OP_MAC, 1'b1, 1'b0, 40'h00_0000_0000, 1'b0, asr_pkg::ASR_WB_DIRECT);
      rd(`ASR_WB_PTR_ADDR, 32'h0000_1234);
      op(asr_pkg::ASR_OP_MAC_NOWB, 1'b1, 1'b0, 40'h00_0000_0000, 1'b0, asr_pkg::ASR_WB_INDIRECT_INC);
      chk({31'h0, xbus_wr_q}, 32'h0000_0000);
      rd(`ASR_WB_PTR_ADDR, 32'h0000_1234);
      chk({24'h00_0000, m_cnt}, 32'h0000_0007);
      report_and_stop();
   end
endmodule : accumulator_saturate_round_bench
bind asr_top asr_properties chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
   .pslverr, .op_valid, .op_kind, .op_wb_mode, .xbus_wr_q, .arith_trap_q);
`default_nettype wire

// *** dv/asr_properties.sv ***
// Port checker for the accumulator datapath top
// Assumes a bind from the bench top file; one pclk domain
`timescale 1ns/1ps
`default_nettype none
module asr_properties (
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [11:0]         paddr,
   input wire logic [31:0]         prdata,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire logic                op_valid,
   input wire asr_pkg::asr_op_type op_kind,
   input wire asr_pkg::asr_wb_type op_wb_mode,
   input wire logic                xbus_wr_q,
   input wire logic                arith_trap_q
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // =====================================================================
   // Operation sequences
   sequence s_wb_op;
      op_valid && op_kind == asr_pkg::ASR_OP_MAC && op_wb_mode == asr_pkg::ASR_WB_INDIRECT_INC;
   endsequence
   sequence s_quiet_op;
      op_valid && (op_kind == asr_pkg::ASR_OP_MAC_NOWB || op_kind == asr_pkg::ASR_OP_ADD);
   endsequence
   // =====================================================================
   // Bus and pulse relations
   a_ready_high: assert property (pready) else $error("pready low");
   a_unmapped_err: assert property (psel && penable && paddr > 12'h024 |-> pslverr) else $error("no slverr");
   a_read_idle: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0000_0000) else $error("prdata");
   a_indirect_write: assert property (s_wb_op |=> xbus_wr_q) else $error("no wb write");
   a_excluded_quiet: assert property (s_quiet_op |=> !xbus_wr_q) else $error("bad write");
   a_store_write: assert property (op_valid && op_kind == asr_pkg::ASR_OP_STORE |=> xbus_wr_q)
      else $error("no store write");
   a_write_cause: assert property (xbus_wr_q |-> $past(op_valid)) else $error("stray write");
   a_trap_cause: assert property (arith_trap_q |-> $past(op_valid) && $past(op_kind) != asr_pkg::ASR_OP_STORE)
      else $error("stray trap");
endmodule : asr_properties
`default_nettype wire

// *** dv/asr_xmem.sv ***
// X data bus partner: keeps the last word written and a count
// Assumes registered one-cycle write pulses from the datapath
`timescale 1ns/1ps
`default_nettype none
module asr_xmem (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        wr,
   input  wire logic [15:0] addr,
   input  wire logic [15:0] data,
   output logic      [15:0] last_addr,
   output logic      [15:0] last_data,
   output logic      [7:0]  n_wr
);
   // Word capture on each write pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_addr <= 16'h0000;
         last_data <= 16'h0000;
         n_wr      <= 8'h00;
      end else if (wr) begin
         last_addr <= addr;
         last_data <= data;
         n_wr      <= n_wr + 8'h01;
      end
   end
endmodule : asr_xmem
`default_nettype wire

// *** pkg/asr_defs.svh ***
// Constants for the accumulator saturate and round datapath
// Assumes a 40-bit accumulator pair, 16-bit data words, APB register access
//
// Summary of operation
// - Sticky limit flag updates per add; software clears
// - Overflow detected at bit 31 or bit 39
// - Saturation off: limit flag follows bit 39 overflow
// - Trap enabled, saturation off: flag set traps
// - Combined guard and sticky bits are ORs
// - Bit-39 mode clamps to 40-bit extremes
// - Bit-31 mode clamps to 32-bit extremes
// - Bit-31 mode never sets guard overflow
// - Catastrophic mode wraps, flag from bit 39
// - MAC write-back of rounded other high word
// - Register-direct write-back loads pointer register
// - Indirect write-back uses pointer, then adds 2
// - Round mode bit picks conventional or convergent
// - No rounding: truncate, drop low word
// - Conventional: increment when low word >= 0x8000
// - Convergent tie: increment only if bit 16 set
// - Store truncated or rounded target accumulator
// - Round output is 16-bit 1.15, wraps without saturation
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

// =====================================================================
// Register byte addresses
`define ASR_CORE_CTRL_ADDR   12'h000
`define ASR_IRQ_CTRL1_ADDR   12'h004
`define ASR_STATUS_ADDR      12'h008
`define ASR_IRQ_STAT_ADDR    12'h00C
`define ASR_IRQ_MASK_ADDR    12'h010
`define ASR_WB_PTR_ADDR      12'h014
`define ASR_ACC_A_LO_ADDR    12'h018
`define ASR_ACC_A_HI_ADDR    12'h01C
`define ASR_ACC_B_LO_ADDR    12'h020
`define ASR_ACC_B_HI_ADDR    12'h024

// =====================================================================
// Field positions
`define ASR_CC_ROUND_SEL_BIT 0
`define ASR_CC_SATA_EN_BIT   1
`define ASR_CC_SATB_EN_BIT   2
`define ASR_CC_SATA_W40_BIT  3
`define ASR_CC_SATB_W40_BIT  4
`define ASR_IC_TRAP_EN_BIT   0
`define ASR_ST_LIMIT_A_BIT   0
`define ASR_ST_LIMIT_B_BIT   1
`define ASR_ST_GUARD_A_BIT   2
`define ASR_ST_GUARD_B_BIT   3
`define ASR_ST_LIMIT_ANY_BIT 4
`define ASR_ST_GUARD_ANY_BIT 5
`define ASR_EV_SAT_A_BIT     0
`define ASR_EV_SAT_B_BIT     1
`define ASR_EV_TRAP_BIT      2

// =====================================================================
// Saturation limits and reset values
`define ASR_MAX40            40'h7F_FFFF_FFFF
`define ASR_MIN40            40'h80_0000_0000
`define ASR_MAX32            40'h00_7FFF_FFFF
`define ASR_MIN32            40'hFF_8000_0000
`define ASR_HALF_LSW         16'h8000
`define ASR_WB_STEP          16'h0002
`define ASR_CORE_CTRL_RST    5'h00
`define ASR_WB_PTR_RST       16'h0000

`endif

// *** pkg/asr_pkg.sv ***
// Types shared by the accumulator saturate and round datapath
// Assumes asr_defs.svh supplies all numeric constants
package asr_pkg;
   // Overflow handling mode of one accumulator
   typedef enum logic [1:0] {
      ASR_MODE_SAT40,
      ASR_MODE_SAT32,
      ASR_MODE_CATASTROPHIC
   } asr_mode_type;

   // Accumulator operation requested by the decoder
   typedef enum logic [2:0] {
      ASR_OP_NONE,
      ASR_OP_ADD,
      ASR_OP_STORE,
      ASR_OP_MAC,
      ASR_OP_MAC_NOWB
   } asr_op_type;

   // Write-back addressing mode
   typedef enum logic [1:0] {
      ASR_WB_NONE,
      ASR_WB_DIRECT,
      ASR_WB_INDIRECT_INC
   } asr_wb_type;
endpackage : asr_pkg

// *** src/asr_round.sv ***
// Round logic: 40-bit accumulator to 16-bit 1.15 word
// Assumes purely combinational use by the accumulator datapath
`timescale 1ns/1ps
`default_nettype none
`include "asr_defs.svh"
module asr_round (
   input  wire logic [39:0] acc,
   input  wire logic        round_en,
   input  wire logic        convergent,
   output logic      [15:0] word
);
   // =====================================================================
   // Round decision
   logic [15:0] acc_high_word;
   logic [15:0] acc_low_word;
   logic        bump;

   // Select increment of high word
   always_comb begin
      acc_high_word = acc[31:16];
      acc_low_word  = acc[15:0];
      bump          = 1'b0;
      if (round_en) begin
         if (convergent && acc_low_word == `ASR_HALF_LSW) begin
            bump = acc[16];
         end else begin
            bump = acc_low_word[15];
         end
      end
      word = acc_high_word + {15'h0000, bump};
   end
endmodule : asr_round
`default_nettype wire

// *** src/asr_sat.sv ***
// Saturation stage for one accumulator result
// Assumes a 41-bit signed sum from the adder/subtracter
`timescale 1ns/1ps
`default_nettype none
`include "asr_defs.svh"
module asr_sat (
   input  wire logic [40:0]          sum,
   input  wire asr_pkg::asr_mode_type mode,
   output logic      [39:0]          result,
   output logic                      limit_hit,
   output logic                      guard_ovf
);
   // =====================================================================
   // Overflow detection and clamp
   logic ovf39;
   logic ovf31;

   always_comb begin
      ovf39     = sum[40] ^ sum[39];
      ovf31     = ~((sum[40:31] == 10'h000) || (sum[40:31] == 10'h3FF));
      result    = sum[39:0];
      limit_hit = 1'b0;
      guard_ovf = 1'b0;
      unique case (mode)
         asr_pkg::ASR_MODE_SAT40: begin
            guard_ovf = ovf31;
            limit_hit = ovf39;
            if (ovf39) begin
               result = sum[40] ? `ASR_MIN40 : `ASR_MAX40;
            end
         end
         asr_pkg::ASR_MODE_SAT32: begin
            guard_ovf = 1'b0;
            limit_hit = ovf31;
            if (ovf31) begin
               result = sum[40] ? `ASR_MIN32 : `ASR_MAX32;
            end
         end
         asr_pkg::ASR_MODE_CATASTROPHIC: begin
            guard_ovf = ovf31;
            limit_hit = ovf39;
         end
         default: ;
      endcase
   end
endmodule : asr_sat
`default_nettype wire

// *** src/asr_top.sv ***
// Accumulator saturation, overflow flags, write-back and store rounding
// Assumes APB master, decoder operation strobes synchronous to pclk
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "asr_defs.svh"
module asr_top (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic                    op_valid,
   input  wire asr_pkg::asr_op_type     op_kind,
   input  wire logic                    op_target_b,
   input  wire logic                    op_subtract,
   input  wire logic [39:0]             op_operand,
   input  wire logic                    op_round,
   input  wire asr_pkg::asr_wb_type     op_wb_mode,
   output logic                         xbus_wr_q,
   output logic      [15:0]             xbus_addr_q,
   output logic      [15:0]             xbus_data_q,
   output logic                         arith_trap_q,
   output logic                         irq
);
   // =====================================================================
   // Register state
   logic [4:0]  core_control_reg_q, core_control_reg_d;
   logic        irq_control_reg_one_q, irq_control_reg_one_d;
   logic [15:0] writeback_pointer_reg_q, writeback_pointer_reg_d;
   logic [39:0] acc_a_q, acc_a_d, acc_b_q, acc_b_d;
   logic        acc_a_sticky_limit_flag_q, acc_a_sticky_limit_flag_d;
   logic        acc_b_sticky_limit_flag_q, acc_b_sticky_limit_flag_d;
   logic        acc_a_guard_overflow_q, acc_a_guard_overflow_d;
   logic        acc_b_guard_overflow_q, acc_b_guard_overflow_d;
   logic [2:0]  irq_stat_q, irq_stat_d;
   logic [2:0]  irq_mask_q, irq_mask_d;
   logic        xbus_wr_d, arith_trap_d;
   logic [15:0] xbus_addr_d, xbus_data_d;
   logic [31:0] prdata_d;

   // Combined status bits
   logic either_acc_sticky_limit;
   logic either_acc_guard_overflow;

   // =====================================================================
   // Mode selection per accumulator
   function automatic asr_pkg::asr_mode_type pick_mode(input logic en, input logic w40);
      if (!en) begin
         pick_mode = asr_pkg::ASR_MODE_CATASTROPHIC;
      end else if (w40) begin
         pick_mode = asr_pkg::ASR_MODE_SAT40;
      end else begin
         pick_mode = asr_pkg::ASR_MODE_SAT32;
      end
   endfunction : pick_mode

   asr_pkg::asr_mode_type mode_a, mode_b, mode_t;
   logic        round_mode_select;
   logic        tgt_sat_en;

   always_comb begin
      mode_a = pick_mode(core_control_reg_q[`ASR_CC_SATA_EN_BIT],
                         core_control_reg_q[`ASR_CC_SATA_W40_BIT]);
      mode_b = pick_mode(core_control_reg_q[`ASR_CC_SATB_EN_BIT],
                         core_control_reg_q[`ASR_CC_SATB_W40_BIT]);
      mode_t = op_target_b ? mode_b : mode_a;
      tgt_sat_en = op_target_b ? core_control_reg_q[`ASR_CC_SATB_EN_BIT]
                               : core_control_reg_q[`ASR_CC_SATA_EN_BIT];
      round_mode_select = core_control_reg_q[`ASR_CC_ROUND_SEL_BIT];
   end

   // =====================================================================
   // Adder/subtracter and saturation of the target accumulator
   logic [39:0] tgt_acc, oth_acc;
   logic [40:0] sum;
   logic [39:0] sat_result;
   logic        limit_hit, guard_ovf;

   always_comb begin
      tgt_acc = op_target_b ? acc_b_q : acc_a_q;
      oth_acc = op_target_b ? acc_a_q : acc_b_q;
      if (op_subtract) begin
         sum = {tgt_acc[39], tgt_acc} - {op_operand[39], op_operand};
      end else begin
         sum = {tgt_acc[39], tgt_acc} + {op_operand[39], op_operand};
      end
   end

   asr_sat u_sat (
      .sum       (sum),
      .mode      (mode_t),
      .result    (sat_result),
      .limit_hit (limit_hit),
      .guard_ovf (guard_ovf)
   );

   // =====================================================================
   // Round logic: store uses target, write-back uses other accumulator
   logic        is_store;
   logic [39:0] round_src;
   logic        round_en;
   logic [15:0] round_word;

   always_comb begin
      is_store  = (op_kind == asr_pkg::ASR_OP_STORE);
      round_src = is_store ? tgt_acc : oth_acc;
      round_en  = is_store ? op_round : 1'b1;
   end

   asr_round u_round (
      .acc        (round_src),
      .round_en   (round_en),
      .convergent (round_mode_select),
      .word       (round_word)
   );

   // =====================================================================
   // APB decode
   logic apb_wr, apb_rd, apb_hit;

   always_comb begin
      apb_wr  = psel && penable && pwrite;
      apb_rd  = psel && penable && !pwrite;
      pready  = 1'b1;
      unique case (paddr)
         `ASR_CORE_CTRL_ADDR, `ASR_IRQ_CTRL1_ADDR, `ASR_STATUS_ADDR,
         `ASR_IRQ_STAT_ADDR, `ASR_IRQ_MASK_ADDR, `ASR_WB_PTR_ADDR,
         `ASR_ACC_A_LO_ADDR, `ASR_ACC_A_HI_ADDR, `ASR_ACC_B_LO_ADDR,
         `ASR_ACC_B_HI_ADDR: apb_hit = 1'b1;
         default:            apb_hit = 1'b0;
      endcase
      pslverr = psel && penable && !apb_hit;
   end

   // =====================================================================
   // Datapath and register next state
   logic sat_evt_a, sat_evt_b, trap_evt;
   logic do_arith, do_wb;

   always_comb begin
      core_control_reg_d        = core_control_reg_q;
      irq_control_reg_one_d     = irq_control_reg_one_q;
      writeback_pointer_reg_d   = writeback_pointer_reg_q;
      acc_a_d                   = acc_a_q;
      acc_b_d                   = acc_b_q;
      acc_a_sticky_limit_flag_d = acc_a_sticky_limit_flag_q;
      acc_b_sticky_limit_flag_d = acc_b_sticky_limit_flag_q;
      acc_a_guard_overflow_d    = acc_a_guard_overflow_q;
      acc_b_guard_overflow_d    = acc_b_guard_overflow_q;
      irq_mask_d                = irq_mask_q;
      xbus_wr_d                 = 1'b0;
      xbus_addr_d               = xbus_addr_q;
      xbus_data_d               = xbus_data_q;
      do_arith = op_valid && (op_kind == asr_pkg::ASR_OP_ADD || op_kind == asr_pkg::ASR_OP_MAC
                              || op_kind == asr_pkg::ASR_OP_MAC_NOWB);
      do_wb    = op_valid && (op_kind == asr_pkg::ASR_OP_MAC)
                 && (op_wb_mode != asr_pkg::ASR_WB_NONE);
      sat_evt_a = do_arith && !op_target_b && limit_hit;
      sat_evt_b = do_arith && op_target_b && limit_hit;
      trap_evt  = (sat_evt_a || sat_evt_b) && !tgt_sat_en
                  && irq_control_reg_one_q;

      // Software writes first, so hardware sets win
      if (apb_wr) begin
         unique case (paddr)
            `ASR_CORE_CTRL_ADDR: core_control_reg_d = pwdata[4:0];
            `ASR_IRQ_CTRL1_ADDR: irq_control_reg_one_d = pwdata[`ASR_IC_TRAP_EN_BIT];
            `ASR_STATUS_ADDR: begin
               acc_a_sticky_limit_flag_d = pwdata[`ASR_ST_LIMIT_A_BIT];
               acc_b_sticky_limit_flag_d = pwdata[`ASR_ST_LIMIT_B_BIT];
               acc_a_guard_overflow_d    = pwdata[`ASR_ST_GUARD_A_BIT];
               acc_b_guard_overflow_d    = pwdata[`ASR_ST_GUARD_B_BIT];
            end
            `ASR_IRQ_MASK_ADDR:  irq_mask_d = pwdata[2:0];
            `ASR_WB_PTR_ADDR:    writeback_pointer_reg_d = pwdata[15:0];
            `ASR_ACC_A_LO_ADDR:  acc_a_d[31:0] = pwdata;
            `ASR_ACC_A_HI_ADDR:  acc_a_d[39:32] = pwdata[7:0];
            `ASR_ACC_B_LO_ADDR:  acc_b_d[31:0] = pwdata;
            `ASR_ACC_B_HI_ADDR:  acc_b_d[39:32] = pwdata[7:0];
            default: ;
         endcase
      end

      // Accumulate into target, update flags
      if (do_arith) begin
         if (op_target_b) begin
            acc_b_d = sat_result;
            acc_b_guard_overflow_d = acc_b_guard_overflow_d | guard_ovf;
            acc_b_sticky_limit_flag_d = acc_b_sticky_limit_flag_d | limit_hit;
         end else begin
            acc_a_d = sat_result;
            acc_a_guard_overflow_d = acc_a_guard_overflow_d | guard_ovf;
            acc_a_sticky_limit_flag_d = acc_a_sticky_limit_flag_d | limit_hit;
         end
      end

      // Store and indirect write-back over the X bus; direct write-back loads the pointer
      if (op_valid && is_store) begin
         xbus_wr_d   = 1'b1;
         xbus_addr_d = writeback_pointer_reg_q;
         xbus_data_d = round_word;
      end else if (do_wb) begin
         if (op_wb_mode == asr_pkg::ASR_WB_DIRECT) begin
            writeback_pointer_reg_d = round_word;
         end else begin
            xbus_wr_d   = 1'b1;
            xbus_addr_d = writeback_pointer_reg_q;
            xbus_data_d = round_word;
            writeback_pointer_reg_d = writeback_pointer_reg_q + `ASR_WB_STEP;
         end
      end
      arith_trap_d = trap_evt;
   end

   // =====================================================================
   // Interrupt status: sticky, cleared by read, set wins
   always_comb begin
      irq_stat_d = irq_stat_q;
      if (apb_rd && paddr == `ASR_IRQ_STAT_ADDR) begin
         irq_stat_d = 3'h0;
      end
      irq_stat_d[`ASR_EV_SAT_A_BIT] = irq_stat_d[`ASR_EV_SAT_A_BIT] | sat_evt_a;
      irq_stat_d[`ASR_EV_SAT_B_BIT] = irq_stat_d[`ASR_EV_SAT_B_BIT] | sat_evt_b;
      irq_stat_d[`ASR_EV_TRAP_BIT]  = irq_stat_d[`ASR_EV_TRAP_BIT] | trap_evt;
      irq = |(irq_stat_q & irq_mask_q);
   end

   // Combined status and read mux
   always_comb begin
      either_acc_sticky_limit   = acc_a_sticky_limit_flag_q | acc_b_sticky_limit_flag_q;
      either_acc_guard_overflow = acc_a_guard_overflow_q | acc_b_guard_overflow_q;
      prdata_d = 32'h0000_0000;
      if (apb_rd) begin
         unique case (paddr)
            `ASR_CORE_CTRL_ADDR: prdata_d = {27'h000_0000, core_control_reg_q};
            `ASR_IRQ_CTRL1_ADDR: prdata_d = {31'h0000_0000, irq_control_reg_one_q};
            `ASR_STATUS_ADDR: prdata_d = {26'h000_0000, either_acc_guard_overflow,
                                          either_acc_sticky_limit, acc_b_guard_overflow_q,
                                          acc_a_guard_overflow_q, acc_b_sticky_limit_flag_q,
                                          acc_a_sticky_limit_flag_q};
            `ASR_IRQ_STAT_ADDR:  prdata_d = {29'h0000_0000, irq_stat_q};
            `ASR_IRQ_MASK_ADDR:  prdata_d = {29'h0000_0000, irq_mask_q};
            `ASR_WB_PTR_ADDR:    prdata_d = {16'h0000, writeback_pointer_reg_q};
            `ASR_ACC_A_LO_ADDR:  prdata_d = acc_a_q[31:0];
            `ASR_ACC_A_HI_ADDR:  prdata_d = {24'h00_0000, acc_a_q[39:32]};
            `ASR_ACC_B_LO_ADDR:  prdata_d = acc_b_q[31:0];
            `ASR_ACC_B_HI_ADDR:  prdata_d = {24'h00_0000, acc_b_q[39:32]};
            default:             prdata_d = 32'h0000_0000;
         endcase
      end
   end

   // Read data is combinational from state during access
   assign prdata = prdata_d;

   // =====================================================================
   // State registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_control_reg_q        <= `ASR_CORE_CTRL_RST;
         irq_control_reg_one_q     <= 1'b0;
         writeback_pointer_reg_q   <= `ASR_WB_PTR_RST;
         acc_a_q                   <= 40'h00_0000_0000;
         acc_b_q                   <= 40'h00_0000_0000;
         acc_a_sticky_limit_flag_q <= 1'b0;
         acc_b_sticky_limit_flag_q <= 1'b0;
         acc_a_guard_overflow_q    <= 1'b0;
         acc_b_guard_overflow_q    <= 1'b0;
         irq_stat_q                <= 3'h0;
         irq_mask_q                <= 3'h0;
         xbus_wr_q                 <= 1'b0;
         xbus_addr_q               <= 16'h0000;
         xbus_data_q               <= 16'h0000;
         arith_trap_q              <= 1'b0;
      end else begin
         core_control_reg_q        <= core_control_reg_d;
         irq_control_reg_one_q     <= irq_control_reg_one_d;
         writeback_pointer_reg_q   <= writeback_pointer_reg_d;
         acc_a_q                   <= acc_a_d;
         acc_b_q                   <= acc_b_d;
         acc_a_sticky_limit_flag_q <= acc_a_sticky_limit_flag_d;
         acc_b_sticky_limit_flag_q <= acc_b_sticky_limit_flag_d;
         acc_a_guard_overflow_q    <= acc_a_guard_overflow_d;
         acc_b_guard_overflow_q    <= acc_b_guard_overflow_d;
         irq_stat_q                <= irq_stat_d;
         irq_mask_q                <= irq_mask_d;
         xbus_wr_q                 <= xbus_wr_d;
         xbus_addr_q               <= xbus_addr_d;
         xbus_data_q               <= xbus_data_d;
         arith_trap_q              <= arith_trap_d;
      end
   end
endmodule : asr_top
`default_nettype wire
